// file: pfc_cfg.svh
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
// Register offsets
`define PFC_OFS_BAL_CTRL 8'h00
`define PFC_OFS_FE_STATUS 8'h01
`define PFC_OFS_FE_CTRL 8'h02
`define PFC_OFS_IRQ_STAT 8'h03
`define PFC_OFS_IRQ_MASK 8'h04
`define PFC_OFS_CAP_NOW 8'h05
`define PFC_OFS_TRIP_LO 8'h06
`define PFC_OFS_TRIP_HI 8'h07
`define PFC_OFS_CHG_STAT 8'h08
`define PFC_OFS_FUSE_DLY 8'h09
// Status register fields
`define PFC_ST_ADAPTER_PERMIT 0
`define PFC_ST_FUSE_RAW 1
`define PFC_ST_FUSE_LATCH 2
`define PFC_ST_FAULT 3
// Control register fields
`define PFC_CT_DSG_EN 0
`define PFC_CT_CHG_EN 1
`define PFC_CT_CHARGER_EN 2
// Interrupt status fields
`define PFC_IRQ_FUSE 0
`define PFC_IRQ_SHUTDOWN 1
`define PFC_IRQ_TERM 2
`define PFC_IRQ_TRIP 3
// Reset values
`define PFC_RST_FE_CTRL 8'h03
`define PFC_RST_FUSE_DLY 16'h0100
// Timing: clock 250 MHz, slow oscillator 262.144 kHz
`define PFC_CLK_HZ 250000000
`define PFC_SLOW_HZ 262144
`define PFC_SLOW_DIV (`PFC_CLK_HZ / `PFC_SLOW_HZ / 2)
`define PFC_SLOW_DIV_W 10
`define PFC_FUSE_SHUT_MS 500
`define PFC_TERM_S 40
`define PFC_LOG_LONG_H 10
`define PFC_LOG_SHORT_H 2
`define PFC_FAST_MUL 64
`define PFC_SHUT_TICKS (`PFC_SLOW_HZ * `PFC_FUSE_SHUT_MS / 1000)
`define PFC_TERM_TICKS (`PFC_SLOW_HZ * `PFC_TERM_S)
`define PFC_HOUR_TICKS (`PFC_SLOW_HZ * 3600)
`endif

// file: pfc_pkg.sv
`default_nettype none
package pfc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfc_bus_req_t;
  typedef struct packed {
    logic [2:0] balance;
    logic charge_switch_gate;
    logic discharge_switch_gate;
    logic adapter_switch_gate;
  } pfc_gates_t;
  typedef enum logic [1:0] {
    PFC_CHG_OFF, PFC_CHG_PRE, PFC_CHG_CCCV, PFC_CHG_DONE
  } pfc_chg_state_t;
endpackage
`default_nettype wire

// file: pfc_protect.sv
// Summary of operation
// - Each of three balance register bits enables one bypass switch.
// - A safety fault turns both protection gates off with no software.
// - Writing both switch enable bits as zero turns both gates off.
// - Adapter gate needs permit set, supply above sense and the rest ok.
// - Raw fuse drive high for the programmed delay sets the fuse latch.
// - Fuse latch still set 500 ms after latching turns both gates off.
// - Cell in window, low current for 40 s ends charge and sets flags.
// - Charger start picks precharge or CC/CV from the lowest cell.
// - Changed logs go out every 10 h, balance and runtime every 2 h.
// - Capacity against two thresholds drives trip interrupt and flag.
// - A 17.86 MHz clock divided from the main clock is halved at 50%.
// - The slow oscillator runs at 262.144 kHz and times every delay.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_protect (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire pfc_pkg::pfc_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic safety_fault_i,
  input wire logic fuse_raw_i,
  input wire logic supply_above_sense_i,
  input wire logic adapter_ok_i,
  input wire logic top_cell_in_window_i,
  input wire logic below_taper_i,
  input wire logic min_cell_low_i,
  input wire logic log_long_diff_i,
  input wire logic log_short_diff_i,
  output pfc_pkg::pfc_gates_t gates_o,
  output logic fuse_drive_output_o,
  output logic precharge_sel_o,
  output logic log_long_write_o,
  output logic log_short_write_o,
  output logic trip_point_interrupt_o,
  output logic fast_oscillator_o,
  output logic half_fast_clk_o,
  output logic irq_o
);
  import pfc_pkg::*;

  // Reset release and input synchronisers
  logic [1:0] rst_sync_ff;
  logic [7:0] meta_ff;
  logic [7:0] sync_ff;
  wire rst_n = rst_sync_ff[1];
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_ff <= 2'b00;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 8'h00;
      sync_ff <= 8'h00;
    end else begin
      meta_ff <= {log_short_diff_i, log_long_diff_i, min_cell_low_i,
                  below_taper_i, top_cell_in_window_i, adapter_ok_i,
                  supply_above_sense_i, safety_fault_i};
      sync_ff <= meta_ff;
    end
  end
  wire s_fault = sync_ff[0];
  wire s_above = sync_ff[1];
  wire s_adapt_ok = sync_ff[2];
  wire s_window = sync_ff[3];
  wire s_taper = sync_ff[4];
  wire s_min_low = sync_ff[5];
  wire s_log_long = sync_ff[6];
  wire s_log_short = sync_ff[7];
  logic [1:0] fuse_meta_ff;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) fuse_meta_ff <= 2'b00;
    else fuse_meta_ff <= {fuse_meta_ff[0], fuse_raw_i};
  end
  wire s_fuse_raw = fuse_meta_ff[1];

  // Slow oscillator tick at 262.144 kHz
  logic [`PFC_SLOW_DIV_W-1:0] slow_cnt_ff;
  logic slow_tick_ff;
  wire slow_wrap = (slow_cnt_ff == `PFC_SLOW_DIV_W'(`PFC_SLOW_DIV * 2 - 1));
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_ff <= '0;
      slow_tick_ff <= 1'b0;
    end else begin
      slow_cnt_ff <= slow_wrap ? '0 : slow_cnt_ff + 1'b1;
      slow_tick_ff <= slow_wrap;
    end
  end

  // Fast clock: slow rate times 64, toggled, then halved
  logic [3:0] fast_cnt_ff;
  logic fast_ff;
  logic half_ff;
  localparam int FAST_DIV = `PFC_CLK_HZ / (`PFC_SLOW_HZ * `PFC_FAST_MUL * 2);
  wire fast_wrap = (fast_cnt_ff == 4'(FAST_DIV - 1));
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_ff <= 4'h0;
      fast_ff <= 1'b0;
      half_ff <= 1'b0;
    end else if (fast_wrap) begin
      fast_cnt_ff <= 4'h0;
      fast_ff <= ~fast_ff;
      if (fast_ff) half_ff <= ~half_ff;
    end else begin
      fast_cnt_ff <= fast_cnt_ff + 4'h1;
    end
  end

  // Register bus decode
  logic [2:0] bal_ff;
  logic [7:0] ctrl_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [7:0] cap_ff;
  logic [7:0] trip_lo_ff;
  logic [7:0] trip_hi_ff;
  logic [15:0] fuse_dly_ff;
  logic fuse_latch_ff;
  logic trip_flag_ff;
  pfc_chg_state_t chg_ff;
  wire wr = bus_i.wr;
  wire [7:0] wd = bus_i.wdata;
  wire wr_bal = wr && bus_i.addr == `PFC_OFS_BAL_CTRL;
  wire wr_st = wr && bus_i.addr == `PFC_OFS_FE_STATUS;
  wire wr_ctrl = wr && bus_i.addr == `PFC_OFS_FE_CTRL;
  wire wr_istat = wr && bus_i.addr == `PFC_OFS_IRQ_STAT;
  wire wr_imask = wr && bus_i.addr == `PFC_OFS_IRQ_MASK;
  wire wr_cap = wr && bus_i.addr == `PFC_OFS_CAP_NOW;
  wire wr_tlo = wr && bus_i.addr == `PFC_OFS_TRIP_LO;
  wire wr_thi = wr && bus_i.addr == `PFC_OFS_TRIP_HI;
  wire wr_fdly = wr && bus_i.addr == `PFC_OFS_FUSE_DLY;
  logic permit_ff;

  // Simple register writes
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bal_ff <= 3'h0;
      ctrl_ff <= `PFC_RST_FE_CTRL;
      irq_mask_ff <= 4'h0;
      cap_ff <= 8'h00;
      trip_lo_ff <= 8'h00;
      trip_hi_ff <= 8'h00;
      fuse_dly_ff <= `PFC_RST_FUSE_DLY;
      permit_ff <= 1'b0;
    end else begin
      if (wr_bal) bal_ff <= wd[2:0];
      if (wr_ctrl) ctrl_ff <= wd;
      if (wr_imask) irq_mask_ff <= wd[3:0];
      if (wr_cap) cap_ff <= wd;
      if (wr_tlo) trip_lo_ff <= wd;
      if (wr_thi) trip_hi_ff <= wd;
      if (wr_fdly) fuse_dly_ff <= {wd, 8'h00};
      if (wr_st) permit_ff <= wd[`PFC_ST_ADAPTER_PERMIT];
    end
  end

  // Fuse detection delay and latch, then delayed shutdown
  logic [15:0] fuse_cnt_ff;
  logic [17:0] shut_cnt_ff;
  logic fuse_shut_ff;
  wire fuse_clr = wr_st && wd[`PFC_ST_FUSE_LATCH];
  wire fuse_set = s_fuse_raw && slow_tick_ff && !fuse_latch_ff
                  && fuse_cnt_ff + 16'h1 >= fuse_dly_ff;
  wire shut_set = fuse_latch_ff && slow_tick_ff && !fuse_shut_ff
                  && shut_cnt_ff == 18'(`PFC_SHUT_TICKS - 1);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fuse_cnt_ff <= 16'h0000;
      fuse_latch_ff <= 1'b0;
      shut_cnt_ff <= 18'h0_0000;
      fuse_shut_ff <= 1'b0;
    end else begin
      if (!s_fuse_raw) fuse_cnt_ff <= 16'h0000;
      else if (slow_tick_ff && fuse_cnt_ff != 16'hFFFF)
        fuse_cnt_ff <= fuse_cnt_ff + 16'h1;
      if (fuse_set) fuse_latch_ff <= 1'b1;
      else if (fuse_clr) fuse_latch_ff <= 1'b0;
      if (!fuse_latch_ff || fuse_clr) shut_cnt_ff <= 18'h0_0000;
      else if (slow_tick_ff && !fuse_shut_ff)
        shut_cnt_ff <= shut_cnt_ff + 18'h1;
      if (shut_set) fuse_shut_ff <= 1'b1;
      else if (fuse_clr) fuse_shut_ff <= 1'b0;
    end
  end

  // Charger start selection and termination timer
  logic [23:0] term_cnt_ff;
  logic term_flag_ff;
  logic pre_ff;
  wire chg_en = ctrl_ff[`PFC_CT_CHARGER_EN];
  wire term_hit = slow_tick_ff && term_cnt_ff == 24'(`PFC_TERM_TICKS - 1);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      chg_ff <= PFC_CHG_OFF;
      term_cnt_ff <= 24'h00_0000;
      term_flag_ff <= 1'b0;
      pre_ff <= 1'b0;
    end else begin
      unique case (chg_ff)
        PFC_CHG_OFF: if (chg_en) begin
          chg_ff <= s_min_low ? PFC_CHG_PRE : PFC_CHG_CCCV;
          pre_ff <= s_min_low;
          term_flag_ff <= 1'b0;
        end
        PFC_CHG_PRE: if (!chg_en) chg_ff <= PFC_CHG_OFF;
          else if (!s_min_low) begin
            chg_ff <= PFC_CHG_CCCV;
            pre_ff <= 1'b0;
          end
        PFC_CHG_CCCV: if (!chg_en) chg_ff <= PFC_CHG_OFF;
          else if (term_hit) begin
            chg_ff <= PFC_CHG_DONE;
            term_flag_ff <= 1'b1;
          end
        PFC_CHG_DONE: if (!chg_en) chg_ff <= PFC_CHG_OFF;
      endcase
      if (chg_ff != PFC_CHG_CCCV || !(s_window && s_taper))
        term_cnt_ff <= 24'h00_0000;
      else if (slow_tick_ff) term_cnt_ff <= term_cnt_ff + 24'h1;
    end
  end

  // Log update schedule on hour counts
  logic [29:0] hour_cnt_ff;
  logic [3:0] hours_ff;
  logic log_l_ff;
  logic log_s_ff;
  wire hour_hit = slow_tick_ff && hour_cnt_ff == 30'(`PFC_HOUR_TICKS - 1);
  wire hours_wrap = hours_ff == 4'(`PFC_LOG_LONG_H - 1);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      hour_cnt_ff <= 30'h0;
      hours_ff <= 4'h0;
      log_l_ff <= 1'b0;
      log_s_ff <= 1'b0;
    end else begin
      log_l_ff <= 1'b0;
      log_s_ff <= 1'b0;
      if (slow_tick_ff) hour_cnt_ff <= hour_hit ? 30'h0 : hour_cnt_ff + 30'h1;
      if (hour_hit) begin
        hours_ff <= hours_wrap ? 4'h0 : hours_ff + 4'h1;
        log_l_ff <= hours_wrap && s_log_long;
        log_s_ff <= hours_ff[0] && s_log_short;
      end
    end
  end

  // Trip point compare: set below low, clear above high
  wire trip_set = cap_ff < trip_lo_ff;
  wire trip_clr = cap_ff > trip_hi_ff;
  wire trip_rise = trip_set && !trip_flag_ff;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) trip_flag_ff <= 1'b0;
    else if (trip_set) trip_flag_ff <= 1'b1;
    else if (trip_clr) trip_flag_ff <= 1'b0;
  end

  // Sticky interrupt status, set wins over write-one clear
  wire [3:0] ev = {trip_rise, term_hit && chg_ff == PFC_CHG_CCCV,
                   shut_set, fuse_set};
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) irq_stat_ff <= 4'h0;
    else irq_stat_ff <= ev | (irq_stat_ff & ~(wr_istat ? wd[3:0] : 4'h0));
  end

  // Gate drive
  wire prot_off = s_fault || fuse_shut_ff;
  wire chg_on = ctrl_ff[`PFC_CT_CHG_EN] && !prot_off && !term_flag_ff;
  wire dsg_on = ctrl_ff[`PFC_CT_DSG_EN] && !prot_off;
  wire ac_on = permit_ff && s_above && s_adapt_ok && !prot_off;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      gates_o <= '0;
      fuse_drive_output_o <= 1'b0;
      precharge_sel_o <= 1'b0;
      trip_point_interrupt_o <= 1'b0;
      irq_o <= 1'b0;
      log_long_write_o <= 1'b0;
      log_short_write_o <= 1'b0;
      fast_oscillator_o <= 1'b0;
      half_fast_clk_o <= 1'b0;
    end else begin
      gates_o.balance <= bal_ff;
      gates_o.charge_switch_gate <= chg_on;
      gates_o.discharge_switch_gate <= dsg_on;
      gates_o.adapter_switch_gate <= ac_on;
      fuse_drive_output_o <= fuse_latch_ff;
      precharge_sel_o <= pre_ff;
      trip_point_interrupt_o <= trip_flag_ff;
      irq_o <= |(irq_stat_ff & irq_mask_ff);
      log_long_write_o <= log_l_ff;
      log_short_write_o <= log_s_ff;
      fast_oscillator_o <= fast_ff;
      half_fast_clk_o <= half_ff;
    end
  end

  // Read mux, data one cycle after strobe
  logic [7:0] rmux;
  always_comb begin
    unique case (bus_i.addr)
      `PFC_OFS_BAL_CTRL: rmux = {5'h00, bal_ff};
      `PFC_OFS_FE_STATUS: rmux = {4'h0, s_fault, fuse_latch_ff,
                                  s_fuse_raw, permit_ff};
      `PFC_OFS_FE_CTRL: rmux = ctrl_ff;
      `PFC_OFS_IRQ_STAT: rmux = {4'h0, irq_stat_ff};
      `PFC_OFS_IRQ_MASK: rmux = {4'h0, irq_mask_ff};
      `PFC_OFS_CAP_NOW: rmux = cap_ff;
      `PFC_OFS_TRIP_LO: rmux = trip_lo_ff;
      `PFC_OFS_TRIP_HI: rmux = trip_hi_ff;
      `PFC_OFS_CHG_STAT: rmux = {4'h0, trip_flag_ff, term_flag_ff, chg_ff};
      `PFC_OFS_FUSE_DLY: rmux = fuse_dly_ff[15:8];
      default: rmux = 8'h00;
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) rdata_o <= 8'h00;
    else rdata_o <= bus_i.rd ? rmux : 8'h00;
  end
endmodule // pfc_protect
`default_nettype wire

// file: pfc_protect_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_protect_asserts (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire pfc_pkg::pfc_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic safety_fault_i,
  input wire logic fuse_raw_i,
  input wire logic supply_above_sense_i,
  input wire pfc_pkg::pfc_gates_t gates_o,
  input wire logic fuse_drive_output_o,
  input wire logic fast_oscillator_o,
  input wire logic half_fast_clk_o
);
  import pfc_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Bus writes of interest
  sequence bal_wr_s;
    bus_i.wr && bus_i.addr == `PFC_OFS_BAL_CTRL;
  endsequence
  sequence off_wr_s;
    bus_i.wr && bus_i.addr == `PFC_OFS_FE_CTRL && bus_i.wdata[1:0] == 2'h0;
  endsequence
  // Fast clock keeps each level for seven cycles
  sequence fast_hold_s;
    $stable(fast_oscillator_o) [*6] ##1 $changed(fast_oscillator_o);
  endsequence
  // Gate, read and clock relations
  balance_reg_a: assert property (bal_wr_s |-> ##2
    gates_o.balance == $past(bus_i.wdata[2:0], 2))
    else $error("balance gates do not follow register");
  fault_off_a: assert property (safety_fault_i [*5] |->
    !gates_o.charge_switch_gate && !gates_o.discharge_switch_gate)
    else $error("gates on during fault");
  cmd_off_a: assert property (off_wr_s |-> ##2
    !gates_o.charge_switch_gate && !gates_o.discharge_switch_gate)
    else $error("gates on after both enables cleared");
  adapter_sense_a: assert property (!supply_above_sense_i [*5] |->
    !gates_o.adapter_switch_gate)
    else $error("adapter gate on without supply");
  fuse_cause_a: assert property ($rose(fuse_drive_output_o) |->
    $past(fuse_raw_i, 4))
    else $error("fuse latched without raw drive");
  read_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  fast_period_a: assert property ($changed(fast_oscillator_o) |=>
    fast_hold_s)
    else $error("fast clock half period wrong");
  half_clock_a: assert property ($changed(half_fast_clk_o) |=>
    $stable(half_fast_clk_o) [*8])
    else $error("halved clock level too short");
endmodule // pfc_protect_asserts
`default_nettype wire

// file: pfc_protect_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); \
  end \
end
module pfc_protect_test;
  import pfc_pkg::*;
  logic clock_i, arst_n_i, fault, fuse_raw, supply, adapter_ok, min_low;
  logic fuse_out, pre_sel, trip, irq;
  logic window, taper, log_diff, log_l, log_s;
  logic log_seen = 1'b0;
  logic [7:0] rdata;
  pfc_bus_req_t bus;
  pfc_gates_t gates;
  int num_errors = 0;
  int tests_run = 0;
  pfc_protect dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .bus_i(bus),
    .rdata_o(rdata), .safety_fault_i(fault), .fuse_raw_i(fuse_raw),
    .supply_above_sense_i(supply), .adapter_ok_i(adapter_ok),
    .top_cell_in_window_i(window), .below_taper_i(taper),
    .min_cell_low_i(min_low), .log_long_diff_i(log_diff),
    .log_short_diff_i(log_diff), .gates_o(gates),
    .fuse_drive_output_o(fuse_out), .precharge_sel_o(pre_sel),
    .log_long_write_o(log_l), .log_short_write_o(log_s),
    .trip_point_interrupt_o(trip), .fast_oscillator_o(),
    .half_fast_clk_o(), .irq_o(irq));
  // Clock at 250 MHz
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Any log write pulse seen during the run
  always @(posedge clock_i) begin
    if (log_l === 1'b1 || log_s === 1'b1) log_seen <= 1'b1;
  end
  // Verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask
  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask
  // Hang guard
  initial begin
    w(20000);
    num_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    arst_n_i = 1'b0;
    bus = '0;
    {fault, fuse_raw, supply, adapter_ok, min_low, window, taper} = 7'h00;
    log_diff = 1'b1;
    w(2);
    arst_n_i <= 1'b1;
    w(4);
    rd(`PFC_OFS_FE_CTRL, `PFC_RST_FE_CTRL, "ctrl reset");
    w(10);
    #1 `CHK("chg gate", 1'b1, gates.charge_switch_gate)
    for (int i = 0; i < 8; i++) begin
      wr(`PFC_OFS_BAL_CTRL, 8'(i));
      w(2);
      #1 `CHK("balance", 3'(i), gates.balance)
      rd(`PFC_OFS_BAL_CTRL, 8'(i), "balance rb");
    end
    for (int i = 0; i < 4; i++) begin
      wr(`PFC_OFS_FE_CTRL, 8'(i));
      w(3);
      #1 `CHK("dsg gate", i[0], gates.discharge_switch_gate)
      `CHK("chg gate", i[1], gates.charge_switch_gate)
    end
    @(posedge clock_i) fault <= 1'b1;
    w(6);
    #1 `CHK("chg fault", 1'b0, gates.charge_switch_gate)
    `CHK("dsg fault", 1'b0, gates.discharge_switch_gate)
    rd(`PFC_OFS_FE_STATUS, 8'h08, "status fault");
    @(posedge clock_i) fault <= 1'b0;
    w(8);
    #1 `CHK("dsg back", 1'b1, gates.discharge_switch_gate)
    for (int i = 0; i < 8; i++) begin
      wr(`PFC_OFS_FE_STATUS, 8'(i & 1));
      @(posedge clock_i);
      supply <= i[1];
      adapter_ok <= i[2];
      w(6);
      #1 `CHK("adapter", i == 7, gates.adapter_switch_gate)
    end
    @(posedge clock_i) min_low <= 1'b1;
    w(4);
    wr(`PFC_OFS_FE_CTRL, 8'h07);
    w(3);
    #1 `CHK("precharge", 1'b1, pre_sel)
    rd(`PFC_OFS_CHG_STAT, 8'h01, "state pre");
    wr(`PFC_OFS_FE_CTRL, 8'h03);
    @(posedge clock_i) min_low <= 1'b0;
    w(4);
    wr(`PFC_OFS_FE_CTRL, 8'h07);
    w(3);
    #1 `CHK("cccv", 1'b0, pre_sel)
    rd(`PFC_OFS_CHG_STAT, 8'h02, "state cccv");
    @(posedge clock_i) {window, taper} <= 2'b11;
    w(8);
    #1 `CHK("no early term", 1'b1, gates.charge_switch_gate)
    rd(`PFC_OFS_CHG_STAT, 8'h02, "still cccv");
    @(posedge clock_i) {window, taper} <= 2'b00;
    wr(`PFC_OFS_FE_CTRL, 8'h03);
    wr(`PFC_OFS_TRIP_LO, 8'h20);
    wr(`PFC_OFS_TRIP_HI, 8'h40);
    wr(`PFC_OFS_IRQ_MASK, 8'h00);
    wr(`PFC_OFS_CAP_NOW, 8'h10);
    w(4);
    #1 `CHK("trip set", 1'b1, trip)
    `CHK("irq masked", 1'b0, irq)
    rd(`PFC_OFS_IRQ_STAT, 8'h08, "irq stat trip");
    wr(`PFC_OFS_IRQ_MASK, 8'h08);
    wr(`PFC_OFS_CAP_NOW, 8'h30);
    w(4);
    #1 `CHK("trip hold", 1'b1, trip)
    `CHK("irq on", 1'b1, irq)
    wr(`PFC_OFS_CAP_NOW, 8'h50);
    w(4);
    #1 `CHK("trip clear", 1'b0, trip)
    wr(`PFC_OFS_IRQ_STAT, 8'h08);
    w(3);
    #1 `CHK("irq cleared", 1'b0, irq)
    rd(8'h3F, 8'h00, "unmapped");
    wr(8'h3F, 8'hFF);
    rd(`PFC_OFS_BAL_CTRL, 8'h07, "balance kept");
    wr(`PFC_OFS_FUSE_DLY, 8'h00);
    wr(`PFC_OFS_IRQ_MASK, 8'h01);
    @(posedge clock_i) fuse_raw <= 1'b1;
    for (int k = 0; k < 3000 && fuse_out !== 1'b1; k++) @(negedge clock_i);
    #1 `CHK("fuse latch", 1'b1, fuse_out)
    `CHK("irq fuse", 1'b1, irq)
    @(posedge clock_i) fuse_raw <= 1'b0;
    w(4);
    wr(`PFC_OFS_FE_STATUS, 8'h05);
    w(3);
    #1 `CHK("fuse clear", 1'b0, fuse_out)
    `CHK("chg kept", 1'b1, gates.charge_switch_gate)
    rd(`PFC_OFS_FE_STATUS, 8'h01, "status clear");
    `CHK("log early", 1'b0, log_seen)
    conclude();
  end
endmodule // pfc_protect_test
bind pfc_protect pfc_protect_asserts u_chk (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .safety_fault_i(safety_fault_i), .fuse_raw_i(fuse_raw_i),
  .supply_above_sense_i(supply_above_sense_i), .gates_o(gates_o),
  .fuse_drive_output_o(fuse_drive_output_o),
  .fast_oscillator_o(fast_oscillator_o), .half_fast_clk_o(half_fast_clk_o));
`default_nettype wire
